// [src/lvmw_map.vh]
// Function
// - any request flag rising low to high wakes the core from sleep or idle
// - enable bits, global one included, never gate the wake-up
// - a flag already high at sleep entry cannot cause a wake-up
// - request flags stay set until serviced or cleared by software
// - servicing a group clears only the group flag, never source flags
// - interrupt entry pushes only the program counter
// - interrupt exit pops the return address and sets the global enable
// - subroutine exit restores the address only, global enable stays clear
// - 8-bit control register, bit5 status, bit4 enable, bits2-0 level
// - level code 000..111 selects 2.0V up to 4.0V
// - enable bit one switches detector on, zero switches it off
// - status reads one while supply is below the selected level
// - detector is off in sleep even with the enable bit set
// - low-supply request flag sets only after a fixed delay of status high
// - low-supply vector call needs global enable, own enable, stack not full
// - servicing clears the low-supply flag and the global enable
`ifndef LVMW_MAP_VH
`define LVMW_MAP_VH
`define LVMW_OFS_CTRL      12'h000
`define LVMW_OFS_IRQ_STAT  12'h004
`define LVMW_OFS_IRQ_MASK  12'h008
`define LVMW_OFS_CPU       12'h00c
`define LVMW_OFS_CPU_STAT  12'h010
`define LVMW_OFS_SRC_FLAGS 12'h014
`define LVMW_CTRL_RESET    8'h00
`define LVMW_BIT_STATUS    5
`define LVMW_BIT_ON        4
`define LVMW_LVL_HI        2
`define LVMW_LVL_LO        0
`define LVMW_NFLAGS        4
`define LVMW_FLAG_LV       0
`define LVMW_FLAG_GRP      1
`define LVMW_CMD_ENTRY     0
`define LVMW_CMD_EXIT_INT  1
`define LVMW_CMD_EXIT_SUB  2
`define LVMW_CMD_SLEEP     3
`define LVMW_CMD_IDLE      4
`define LVMW_CMD_GRP_CLR   5
`define LVMW_CMD_LV_EN     6
`define LVMW_CMD_GIE_SET   7
`define LVMW_BIT_LV_EN_VAL 8
`define LVMW_IRQ_DELAY_NS  15000
`define LVMW_CLK_NS        40
`endif

// [src/lvmw_sync2.v]
`timescale 1ns/1ps
`default_nettype none
module lvmw_sync2 (
    input  wire clk_in,
    input  wire sys_rst_in,
    input  wire async_in,
    output wire sync_out
);
    reg meta_ff;
    reg sync_ff;
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end
    assign sync_out = sync_ff;
endmodule // lvmw_sync2
`default_nettype wire

// [src/lvmw_delay.v]
`timescale 1ns/1ps
`default_nettype none
// qualifies a level: done goes high once the level has stood for count cycles
module lvmw_delay #(
    parameter W     = 16,
    parameter COUNT = 375
) (
    input  wire clk_in,
    input  wire sys_rst_in,
    input  wire level_in,
    output wire done_out
);
    localparam [W-1:0] LAST = COUNT - 1;
    reg [W-1:0] cnt_ff;
    reg         done_ff;
    always @(posedge clk_in) begin
        if (sys_rst_in || !level_in) begin
            cnt_ff  <= {W{1'b0}};
            done_ff <= 1'b0;
        end else if (cnt_ff == LAST) begin
            done_ff <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
        end
    end
    assign done_out = done_ff;
endmodule // lvmw_delay
`default_nettype wire

// [src/lvmw_top.v]
`timescale 1ns/1ps
`default_nettype none
`include "lvmw_map.vh"
module lvmw_top #(
    parameter STACK_DEPTH = 4
) (
    input  wire        clk_in,
    input  wire        sys_rst_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [11:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    input  wire        supply_below_in,
    input  wire        ext_flag_set_in,
    output reg         detector_power_out,
    output reg  [2:0]  trip_level_out,
    output reg         wake_out,
    output reg         vector_call_out,
    output reg         irq_out
);
    localparam integer DELAY_CYC =
        (`LVMW_IRQ_DELAY_NS + `LVMW_CLK_NS - 1) / `LVMW_CLK_NS;
    localparam N = `LVMW_NFLAGS;

    reg        detector_on_ff;
    reg [2:0]  trip_level_select_ff;
    reg [N-1:0] flags_ff;
    reg [N-1:0] flags_at_sleep_ff;
    reg [3:0]  src_flags_ff;
    reg        global_irq_enable_ff;
    reg        supply_low_irq_enable_ff;
    reg        asleep_ff;
    reg        in_sleep_ff;
    reg [3:0]  sp_ff;
    reg        pc_pushed_ff;
    reg [1:0]  ev_stat_ff;
    reg [1:0]  ev_mask_ff;

    wire cmp_sync;
    wire lv_delay_done;
    reg  lv_done_d_ff;

    // comparator is only powered when enabled and not in sleep
    wire det_active = detector_on_ff && !in_sleep_ff;
    wire supply_low_status = det_active && cmp_sync;

    lvmw_sync2 u_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .async_in   (supply_below_in),
        .sync_out   (cmp_sync)
    );

    lvmw_delay #(.W(16), .COUNT(DELAY_CYC)) u_delay (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .level_in   (supply_low_status),
        .done_out   (lv_delay_done)
    );

    wire acc = psel_in && penable_in && !pready_out;
    wire wr  = acc && pwrite_in;
    wire cmd_wr = wr && (paddr_in == `LVMW_OFS_CPU);
    wire [31:0] cmd = cmd_wr ? pwdata_in : 32'h0000_0000;
    wire stack_full = (sp_ff == STACK_DEPTH[3:0]);

    // vector call for the low-supply source
    wire lv_call = cmd[`LVMW_CMD_ENTRY] && global_irq_enable_ff &&
                   supply_low_irq_enable_ff && flags_ff[`LVMW_FLAG_LV] &&
                   !stack_full;
    wire lv_set = lv_delay_done && !lv_done_d_ff;
    wire [N-1:0] sw_clr = (wr && paddr_in == `LVMW_OFS_CPU_STAT) ?
                          pwdata_in[N-1:0] : {N{1'b0}};
    // a source event raises the group flag once; a source bit left set must
    // not raise it again after servicing, or the group would re-enter forever
    wire grp_set = ext_flag_set_in;
    reg  [N-1:0] nxt_flags;
    reg  [N-1:0] set_vec;
    reg  [N-1:0] clr_vec;
    always @* begin
        set_vec = {N{1'b0}};
        clr_vec = sw_clr;
        set_vec[`LVMW_FLAG_LV]  = lv_set;
        set_vec[`LVMW_FLAG_GRP] = grp_set;
        set_vec[N-1] = ext_flag_set_in;
        if (lv_call)
            clr_vec[`LVMW_FLAG_LV] = 1'b1;
        if (cmd[`LVMW_CMD_GRP_CLR])
            clr_vec[`LVMW_FLAG_GRP] = 1'b1;
        // set wins over clear; flags otherwise hold
        nxt_flags = (flags_ff & ~clr_vec) | set_vec;
    end

    // wake on any rise relative to the snapshot, no enable involved
    wire [N-1:0] rose = flags_ff & ~flags_at_sleep_ff;
    wire wake = asleep_ff && (|rose);

    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            detector_on_ff           <= 1'b0;
            trip_level_select_ff     <= 3'h0;
            flags_ff                 <= {N{1'b0}};
            flags_at_sleep_ff        <= {N{1'b0}};
            src_flags_ff             <= 4'h0;
            global_irq_enable_ff     <= 1'b0;
            supply_low_irq_enable_ff <= 1'b0;
            asleep_ff                <= 1'b0;
            in_sleep_ff              <= 1'b0;
            sp_ff                    <= 4'h0;
            pc_pushed_ff             <= 1'b0;
            ev_stat_ff               <= 2'h0;
            ev_mask_ff               <= 2'h0;
            lv_done_d_ff             <= 1'b0;
            prdata_out               <= 32'h0000_0000;
            pready_out               <= 1'b0;
            pslverr_out              <= 1'b0;
            detector_power_out       <= 1'b0;
            trip_level_out           <= 3'h0;
            wake_out                 <= 1'b0;
            vector_call_out          <= 1'b0;
            irq_out                  <= 1'b0;
        end else begin
            lv_done_d_ff <= lv_delay_done;
            flags_ff     <= nxt_flags;
            pready_out   <= acc;
            pslverr_out  <= 1'b0;
            pc_pushed_ff <= 1'b0;
            if (wr && paddr_in == `LVMW_OFS_CTRL) begin
                detector_on_ff       <= pwdata_in[`LVMW_BIT_ON];
                trip_level_select_ff <= pwdata_in[`LVMW_LVL_HI:`LVMW_LVL_LO];
            end
            if (wr && paddr_in == `LVMW_OFS_SRC_FLAGS)
                src_flags_ff <= src_flags_ff & ~pwdata_in[3:0];
            if (cmd[`LVMW_CMD_LV_EN])
                supply_low_irq_enable_ff <= pwdata_in[`LVMW_BIT_LV_EN_VAL];
            if (cmd[`LVMW_CMD_SLEEP] || cmd[`LVMW_CMD_IDLE]) begin
                asleep_ff         <= 1'b1;
                in_sleep_ff       <= cmd[`LVMW_CMD_SLEEP];
                flags_at_sleep_ff <= nxt_flags;
            end else if (wake) begin
                asleep_ff   <= 1'b0;
                in_sleep_ff <= 1'b0;
            end
            if (lv_call) begin
                sp_ff                <= sp_ff + 4'h1;
                pc_pushed_ff         <= 1'b1;
                global_irq_enable_ff <= 1'b0;
            end else if (cmd[`LVMW_CMD_EXIT_INT] && sp_ff != 4'h0) begin
                sp_ff                <= sp_ff - 4'h1;
                global_irq_enable_ff <= 1'b1;
            end else if (cmd[`LVMW_CMD_EXIT_SUB] && sp_ff != 4'h0) begin
                sp_ff <= sp_ff - 4'h1;
            end else if (cmd[`LVMW_CMD_GIE_SET]) begin
                global_irq_enable_ff <= 1'b1;
            end
            // sticky events: wake, low-supply flag set; set wins over clear
            if (wr && paddr_in == `LVMW_OFS_IRQ_STAT)
                ev_stat_ff <= (ev_stat_ff & ~pwdata_in[1:0]) | {lv_set, wake};
            else
                ev_stat_ff <= ev_stat_ff | {lv_set, wake};
            if (wr && paddr_in == `LVMW_OFS_IRQ_MASK)
                ev_mask_ff <= pwdata_in[1:0];
            irq_out            <= |(ev_stat_ff & ev_mask_ff);
            detector_power_out <= det_active;
            trip_level_out     <= trip_level_select_ff;
            wake_out           <= wake;
            vector_call_out    <= lv_call;
            if (acc && !pwrite_in) begin
                case (paddr_in)
                    `LVMW_OFS_CTRL: prdata_out <= {24'h000000, 2'b00, supply_low_status,
                                                   detector_on_ff, 1'b0,
                                                   trip_level_select_ff};
                    `LVMW_OFS_IRQ_STAT:  prdata_out <= {30'h0, ev_stat_ff};
                    `LVMW_OFS_IRQ_MASK:  prdata_out <= {30'h0, ev_mask_ff};
                    `LVMW_OFS_CPU_STAT:  prdata_out <= {20'h00000, sp_ff,
                                          asleep_ff, in_sleep_ff,
                                          supply_low_irq_enable_ff,
                                          global_irq_enable_ff, flags_ff};
                    `LVMW_OFS_SRC_FLAGS: prdata_out <= {28'h0, src_flags_ff};
                    `LVMW_OFS_CPU:       prdata_out <= 32'h0000_0000;
                    default: begin
                        prdata_out  <= 32'h0000_0000;
                        pslverr_out <= 1'b1;
                    end
                endcase
            end else if (acc) begin
                if (paddr_in > `LVMW_OFS_SRC_FLAGS || paddr_in[1:0] != 2'b00)
                    pslverr_out <= 1'b1;
            end
            // group sources: ext pulse latches into source bit 0
            if (ext_flag_set_in)
                src_flags_ff[0] <= 1'b1;
        end
    end
endmodule // lvmw_top
`default_nettype wire

// [testbench/lvmw_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module lvmw_chk (
    input wire        clk_in,
    input wire        sys_rst_in,
    input wire        psel_in,
    input wire        penable_in,
    input wire        pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [31:0] prdata_out,
    input wire        pready_out,
    input wire        pslverr_out,
    input wire        supply_below_in,
    input wire        ext_flag_set_in,
    input wire        detector_power_out,
    input wire [2:0]  trip_level_out,
    input wire        wake_out,
    input wire        vector_call_out,
    input wire        irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    wire acc_taken = psel_in && penable_in && !pready_out;
    sequence wr_at(a);
        acc_taken && pwrite_in && paddr_in == a;
    endsequence
    sequence rd_ctrl;
        acc_taken && !pwrite_in && paddr_in == 12'h000;
    endsequence
    one_wait_a: assert property (acc_taken |=> pready_out ##1 !pready_out)
        else $error("ready not one wait state pulse");
    err_pair_a: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    unmapped_err_a: assert property (acc_taken && paddr_in > 12'h014 |=> pslverr_out)
        else $error("unmapped access not refused");
    level_copy_a: assert property (wr_at(12'h000) |=> ##1 trip_level_out == $past(pwdata_in[2:0], 2))
        else $error("trip level not copied");
    det_off_a: assert property (wr_at(12'h000) and !pwdata_in[4] |=> ##1 !detector_power_out)
        else $error("detector stays powered");
    sleep_off_a: assert property (wr_at(12'h00c) and pwdata_in[3] |=> ##1 !detector_power_out)
        else $error("detector powered in sleep");
    ctrl_zero_a: assert property (rd_ctrl |=> prdata_out[31:6] == 26'h0 && !prdata_out[3])
        else $error("unused control bits not zero");
    ctrl_level_a: assert property (rd_ctrl |=> prdata_out[2:0] == trip_level_out)
        else $error("level readback differs");
    mask_quiet_a: assert property (wr_at(12'h008) and pwdata_in[1:0] == 2'h0 |=> ##1 !irq_out)
        else $error("irq with all masked");
endmodule // lvmw_chk
bind lvmw_top lvmw_chk i_chk (.clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .supply_below_in,
    .ext_flag_set_in, .detector_power_out, .trip_level_out, .wake_out, .vector_call_out,
    .irq_out);
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int DLY = 375;
    logic        clk_in = 0, sys_rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic [11:0] paddr_in = 0;
    logic [31:0] pwdata_in = 0, rd;
    logic        supply_below_in = 0, ext_flag_set_in = 0, err;
    wire  [31:0] prdata_out;
    wire  [2:0]  trip_level_out;
    wire         pready_out, pslverr_out, detector_power_out, wake_out, vector_call_out, irq_out;
    int          miscompares = 0, tests_run = 0, cycles = 0, wakes = 0, calls = 0;
    int          seed = 1, model_ctrl, w0, i;
    always #20 clk_in = ~clk_in;
    lvmw_top i_lvmw_top (.clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .supply_below_in,
        .ext_flag_set_in, .detector_power_out, .trip_level_out, .wake_out,
        .vector_call_out, .irq_out);
    task chk(input logic [31:0] seen, exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'h1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'h1;
        @(posedge clk_in);
        while (pready_out !== 1'h1) @(posedge clk_in);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'h0;
        penable_in <= 1'h0;
    endtask
    task pulse_ext;
        ext_flag_set_in <= 1'h1;
        @(posedge clk_in);
        ext_flag_set_in <= 1'h0;
    endtask
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        wakes <= wakes + int'(wake_out);
        calls <= calls + int'(vector_call_out);
        if (cycles == 5000) begin
            miscompares++;
            close_out;
        end
    end
    initial begin
        repeat (16) @(posedge clk_in);
        sys_rst_in <= 1'h0;
        apb(0, 12'h000, 0); chk(rd, 0, "ctrl reset");
        for (i = 0; i < 8; i++) begin
            model_ctrl = i;
            // random upper bits, status bit among them, must not stick
            apb(1, 12'h000, ($random(seed) & 32'hffffffe8) | i);
            apb(0, 12'h000, 0); chk(rd, model_ctrl, "ctrl level");
            chk(trip_level_out, i, "trip level");
        end
        model_ctrl = 32'h13;
        apb(1, 12'h000, model_ctrl);
        supply_below_in <= 1'h1;
        repeat (4) @(posedge clk_in); // settle time before status is trusted
        chk(detector_power_out, 1, "power on");
        apb(0, 12'h000, 0); chk(rd, model_ctrl | 32'h20, "status low");
        repeat (DLY - 30) @(posedge clk_in);
        apb(0, 12'h010, 0); chk(rd[0], 0, "early flag");
        repeat (40) @(posedge clk_in);
        apb(0, 12'h010, 0); chk(rd[0], 1, "late flag");
        supply_below_in <= 1'h0;
        apb(1, 12'h008, 32'h2);
        repeat (2) @(posedge clk_in);
        chk(irq_out, 1, "irq on");
        apb(1, 12'h008, 32'h0);
        apb(1, 12'h008, 32'h2);
        apb(1, 12'h004, 32'h3);
        apb(0, 12'h004, 0); chk(rd, 0, "event clr");
        chk(irq_out, 0, "irq off");
        apb(0, 12'h010, 0); chk(rd[0], 1, "flag kept");
        apb(1, 12'h00c, 32'h1c0);
        apb(1, 12'h00c, 32'h1);
        for (i = 0; i < 50 && calls == 0; i++) @(posedge clk_in);
        chk(calls, 1, "vector call");
        apb(0, 12'h010, 0); chk(rd[11:0], 12'h120, "serviced");
        apb(1, 12'h00c, 32'h4);
        apb(0, 12'h010, 0); chk(rd[11:4], 8'h02, "sub exit");
        // a second low-supply episode gives a fresh flag for a second call
        supply_below_in <= 1'h1;
        repeat (DLY + 20) @(posedge clk_in);
        supply_below_in <= 1'h0;
        apb(1, 12'h00c, 32'h80);
        apb(1, 12'h00c, 32'h1);
        apb(0, 12'h010, 0); chk(rd[11:0], 12'h120, "second call");
        apb(1, 12'h00c, 32'h2);
        apb(0, 12'h010, 0); chk(rd[11:4], 8'h03, "int exit");
        pulse_ext;
        apb(1, 12'h00c, 32'h20);
        apb(0, 12'h010, 0); chk(rd[3:0], 4'h8, "group clr");
        apb(0, 12'h014, 0); chk(rd[0], 1, "source kept");
        for (i = 0; i < 2; i++) begin
            apb(1, 12'h010, 32'h2);
            w0 = wakes;
            apb(1, 12'h00c, i ? 32'h10 : 32'h8);
            repeat (10) @(posedge clk_in);
            chk(wakes, w0, "held flag");
            if (i == 0) chk(detector_power_out, 0, "sleep power");
            apb(1, 12'h010, 32'hf);
            pulse_ext;
            repeat (10) @(posedge clk_in);
            chk(wakes, w0 + 1, "wake");
        end
        apb(0, 12'h018, 0); chk(err, 1, "unmapped");
        apb(0, 12'h002, 0); chk(err, 1, "unaligned");
        apb(0, 12'h000, 0); chk(err, 0, "mapped");
        close_out;
    end
endmodule // testbench
`default_nettype wire
